// [include/lsu_pkg.sv]
// ---------------------------------------------------------------------------
// lin sync unit constants
// ---------------------------------------------------------------------------
package lsu_pkg;

  // ---------------------------------------------------------------------------
  // clocking and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ        = 125_000_000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int LP_OSC_HZ     = 131_000;
  localparam int SYNC_CLK_HZ   = 5_000_000;
  localparam int LP_DIV        = CLK_HZ / LP_OSC_HZ;
  localparam int SYNC_DIV      = CLK_HZ / SYNC_CLK_HZ;
  localparam int SELF_CLR_NS   = 15_000;
  localparam int SELF_CLR_CYC  = (SELF_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [10:0] SELF_CLR_LAST = 11'(SELF_CLR_CYC - 1);

  // ---------------------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [31:0] ADDR_SYNC_CONTROL = 32'hFFFF0780;
  localparam logic [31:0] ADDR_SYNC_STATUS  = 32'hFFFF0784;
  localparam logic [31:0] ADDR_SYNC_VALUE   = 32'hFFFF0788;
  localparam logic [31:0] ADDR_EDGE_SETUP   = 32'hFFFF078C;
  localparam logic [31:0] ADDR_BREAK_TIMER  = 32'hFFFF0790;

  typedef enum logic [2:0] {
    SEL_NONE  = 3'h0,
    SEL_CTL   = 3'h1,
    SEL_STS   = 3'h2,
    SEL_VAL   = 3'h3,
    SEL_SETUP = 3'h4,
    SEL_BRK   = 3'h5
  } lsu_sel_t;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int CTL_RST      = 0;
  localparam int CTL_ECLR     = 1;
  localparam int CTL_EN       = 2;
  localparam int CTL_START_IE = 3;
  localparam int CTL_STOP_IE  = 4;
  localparam int CTL_EDGE_RISE = 7;
  localparam int STS_BRK      = 0;
  localparam int STS_STOP     = 1;
  localparam int STS_START    = 2;
  localparam int STS_ERR      = 4;
  localparam int STS_RDONE    = 5;
  localparam int SETUP_START_LSB = 0;
  localparam int SETUP_STOP_LSB  = 4;

  // ---------------------------------------------------------------------------
  // reset values and break timer limit
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  SETUP_RST = 8'h32;
  localparam logic [11:0] CMP_RST   = 12'h047;
  localparam logic [15:0] VAL_RST   = 16'h0000;
  localparam logic [11:0] BRK_MAX   = 12'hFFF;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b11
  } lsu_sync_st_t;

endpackage

// [rtl/lsu_tick_div.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// one-cycle enable every DIV clocks
// ---------------------------------------------------------------------------
module lsu_tick_div #(
  parameter int DIV = 25
) (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic run,
  output logic      tick
);
  localparam logic [9:0] LAST = 10'(DIV - 1);

  typedef struct packed {
    logic [9:0] cnt;
    logic       tick;
  } lsu_div_t;

  lsu_div_t s_r;
  lsu_div_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!run) begin
      s_nxt.cnt = 10'h000;
    end else if (s_r.cnt == LAST) begin
      s_nxt.cnt  = 10'h000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 10'h001;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule

// [rtl/lsu_lin_sync.sv]
// Local design decision: the APB register port.
`timescale 1ns/1ps
module lsu_lin_sync
  import lsu_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lin_rx,
  output logic             lin_irq
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic         en;
    logic         start_ie;
    logic         stop_ie;
    logic         edge_rise;
    logic         rst_busy;
    logic [10:0]  rst_cnt;
    logic         eclr_busy;
    logic [10:0]  eclr_cnt;
    logic [7:0]   setup;
    logic [11:0]  cmp;
    logic [11:0]  brk;
    logic         brk_run;
    logic         brk_ok;
    logic [3:0]   fcnt;
    logic [3:0]   rcnt;
    logic [15:0]  sval;
    lsu_sync_st_t st;
    logic         f_brk;
    logic         f_stop;
    logic         f_start;
    logic         f_err;
    logic         f_rdone;
    logic         lin_q;
    logic [31:0]  prdata;
    logic         pslverr;
  } lsu_state_t;

  lsu_state_t s_r;
  lsu_state_t s_nxt;

  logic       tick_lp;
  logic       tick_sy;
  logic       active;
  logic       fall;
  logic       rise;
  logic       brk_hit;
  logic       ovf;
  logic       stop_hit;
  logic       wr_acc;
  logic       rd_acc;
  lsu_sel_t   sel;

  // ---------------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------------
  function automatic lsu_sel_t lsu_decode(input logic [31:0] a);
    if (a == ADDR_SYNC_CONTROL) begin
      return SEL_CTL;
    end else if (a == ADDR_SYNC_STATUS) begin
      return SEL_STS;
    end else if (a == ADDR_SYNC_VALUE) begin
      return SEL_VAL;
    end else if (a == ADDR_EDGE_SETUP) begin
      return SEL_SETUP;
    end else if (a == ADDR_BREAK_TIMER) begin
      return SEL_BRK;
    end else begin
      return SEL_NONE;
    end
  endfunction

  assign active = s_r.en & ~s_r.rst_busy;
  assign fall   = s_r.lin_q & ~lin_rx;
  assign rise   = ~s_r.lin_q & lin_rx;
  assign sel    = lsu_decode(paddr);
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;

  // ---------------------------------------------------------------------------
  // rate enables
  // ---------------------------------------------------------------------------
  lsu_tick_div #(.DIV(LP_DIV)) u_lp_div (
    .clock (clock),
    .rst_b (rst_b),
    .run   (active),
    .tick  (tick_lp)
  );

  lsu_tick_div #(.DIV(SYNC_DIV)) u_sy_div (
    .clock (clock),
    .rst_b (rst_b),
    .run   (active),
    .tick  (tick_sy)
  );

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    s_nxt    = s_r;
    brk_hit  = 1'b0;
    ovf      = 1'b0;
    stop_hit = 1'b0;
    s_nxt.lin_q = lin_rx;

    // setup phase: capture read data
    if (psel && !penable) begin
      s_nxt.pslverr = (sel == SEL_NONE);
      s_nxt.prdata  = 32'h00000000;
      if (sel == SEL_CTL) begin
        s_nxt.prdata[CTL_RST]       = s_r.rst_busy;
        s_nxt.prdata[CTL_ECLR]      = s_r.eclr_busy;
        s_nxt.prdata[CTL_EN]        = s_r.en;
        s_nxt.prdata[CTL_START_IE]  = s_r.start_ie;
        s_nxt.prdata[CTL_STOP_IE]   = s_r.stop_ie;
        s_nxt.prdata[CTL_EDGE_RISE] = s_r.edge_rise;
      end else if (sel == SEL_STS) begin
        s_nxt.prdata[STS_BRK]   = s_r.f_brk;
        s_nxt.prdata[STS_STOP]  = s_r.f_stop;
        s_nxt.prdata[STS_START] = s_r.f_start;
        s_nxt.prdata[STS_ERR]   = s_r.f_err;
        s_nxt.prdata[STS_RDONE] = s_r.f_rdone;
      end else if (sel == SEL_VAL) begin
        s_nxt.prdata[15:0] = s_r.sval;
      end else if (sel == SEL_SETUP) begin
        s_nxt.prdata[7:0] = s_r.setup;
      end else if (sel == SEL_BRK) begin
        s_nxt.prdata[11:0] = s_r.brk;
      end
    end

    // access phase: writes and read side effects
    if (wr_acc && sel == SEL_CTL) begin
      s_nxt.en        = pwdata[CTL_EN];
      s_nxt.start_ie  = pwdata[CTL_START_IE];
      s_nxt.stop_ie   = pwdata[CTL_STOP_IE];
      s_nxt.edge_rise = pwdata[CTL_EDGE_RISE];
      if (pwdata[CTL_RST]) begin
        s_nxt.rst_busy = 1'b1;
        s_nxt.rst_cnt  = 11'h000;
        s_nxt.f_rdone  = 1'b0;
      end
      if (pwdata[CTL_ECLR]) begin
        s_nxt.eclr_busy = 1'b1;
        s_nxt.eclr_cnt  = 11'h000;
      end
    end
    if (wr_acc && sel == SEL_SETUP) begin
      s_nxt.setup = pwdata[7:0];
    end
    if (wr_acc && sel == SEL_BRK) begin
      s_nxt.cmp = pwdata[11:0];
    end
    if (rd_acc && sel == SEL_BRK) begin
      s_nxt.brk = 12'h000;
    end
    if (rd_acc && sel == SEL_STS) begin
      s_nxt.f_brk   = 1'b0;
      s_nxt.f_stop  = 1'b0;
      s_nxt.f_start = 1'b0;
      s_nxt.f_err   = 1'b0;
    end

    // break timer: events below override the clears above
    if (active) begin
      if (fall) begin
        s_nxt.brk     = 12'h000;
        s_nxt.brk_run = 1'b1;
      end else if (rise) begin
        s_nxt.brk_run = 1'b0;
      end else if (s_r.brk_run && tick_lp && !lin_rx) begin
        if (s_nxt.brk == BRK_MAX) begin
          ovf           = 1'b1;
          s_nxt.brk     = 12'h000;
          s_nxt.brk_run = 1'b0;
          s_nxt.f_err   = 1'b1;
        end else begin
          s_nxt.brk = s_nxt.brk + 12'h001;
          brk_hit   = (s_nxt.brk == s_r.cmp);
        end
      end
    end

    // a matched break restarts the sync measurement
    if (brk_hit) begin
      s_nxt.f_brk  = 1'b1;
      s_nxt.brk_ok = 1'b1;
      s_nxt.fcnt   = 4'h1;
      s_nxt.rcnt   = 4'h0;
      s_nxt.sval   = VAL_RST;
      s_nxt.st     = ST_IDLE;
    end else if (active && s_r.brk_ok) begin
      if (fall && s_r.fcnt != 4'hF) begin
        s_nxt.fcnt = s_r.fcnt + 4'h1;
      end
      if (rise && s_r.rcnt != 4'hF) begin
        s_nxt.rcnt = s_r.rcnt + 4'h1;
      end
      case (s_r.st)
        ST_IDLE: begin
          if (fall && s_nxt.fcnt == s_r.setup[SETUP_START_LSB +: 4]) begin
            s_nxt.st      = ST_RUN;
            s_nxt.sval    = VAL_RST;
            s_nxt.f_start = 1'b1;
          end
        end
        ST_RUN: begin
          if (tick_sy) begin
            s_nxt.sval = s_r.sval + 16'h0001;
          end
          if (s_r.edge_rise) begin
            stop_hit = rise && (s_nxt.rcnt == s_r.setup[SETUP_STOP_LSB +: 4]);
          end else begin
            stop_hit = fall && (s_nxt.fcnt == s_r.setup[SETUP_STOP_LSB +: 4]);
          end
          if (stop_hit) begin
            s_nxt.st     = ST_DONE;
            s_nxt.f_stop = 1'b1;
          end
        end
        ST_DONE: begin
          s_nxt.st = ST_DONE;
        end
        default: begin
          s_nxt.st = ST_IDLE;
        end
      endcase
    end

    // edge counter clear, self-timed
    if (s_r.eclr_busy) begin
      s_nxt.fcnt = 4'h0;
      s_nxt.rcnt = 4'h0;
      if (s_r.eclr_cnt == SELF_CLR_LAST) begin
        s_nxt.eclr_busy = 1'b0;
      end else begin
        s_nxt.eclr_cnt = s_r.eclr_cnt + 11'h001;
      end
    end

    // sync reset: hold defaults for the self-clear time
    if (s_r.rst_busy) begin
      s_nxt.setup   = SETUP_RST;
      s_nxt.cmp     = CMP_RST;
      s_nxt.brk     = 12'h000;
      s_nxt.brk_run = 1'b0;
      s_nxt.brk_ok  = 1'b0;
      s_nxt.fcnt    = 4'h0;
      s_nxt.rcnt    = 4'h0;
      s_nxt.sval    = VAL_RST;
      s_nxt.st      = ST_IDLE;
      s_nxt.f_brk   = 1'b0;
      s_nxt.f_stop  = 1'b0;
      s_nxt.f_start = 1'b0;
      s_nxt.f_err   = 1'b0;
      if (s_r.rst_cnt == SELF_CLR_LAST) begin
        s_nxt.rst_busy = 1'b0;
        s_nxt.f_rdone  = 1'b1;
      end else begin
        s_nxt.rst_cnt = s_r.rst_cnt + 11'h001;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_r         <= '0;
      s_r.setup   <= SETUP_RST;
      s_r.cmp     <= CMP_RST;
      s_r.sval    <= VAL_RST;
      s_r.st      <= ST_IDLE;
      s_r.f_rdone <= 1'b1;
      s_r.lin_q   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata  = s_r.prdata;
  assign pslverr = s_r.pslverr;
  assign pready  = 1'b1;
  assign lin_irq = s_r.f_brk | s_r.f_err
                 | (s_r.f_stop & s_r.stop_ie)
                 | (s_r.f_start & s_r.start_ie);

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_brk_fall_clear: assert property (active && fall |=> s_r.brk == 12'h000)
    else $error("break timer not cleared by falling edge");
  a_brk_read_clear: assert property (rd_acc && sel == SEL_BRK |=> s_r.brk <= 12'h001)
    else $error("break timer not cleared by read");
  a_cmp_hit_irq: assert property (
    brk_hit |=> s_r.f_brk && lin_irq && s_r.fcnt == 4'h1)
    else $error("compare match did not flag break");
  a_ovf_error: assert property (ovf |=> s_r.f_err && lin_irq && !s_r.brk_run)
    else $error("overflow did not flag break error");
  a_run_needs_brk: assert property (s_r.st != ST_IDLE |-> s_r.brk_ok)
    else $error("sync timing without a valid break");
  a_done_hold: assert property (
    s_r.st == ST_DONE ##1 s_r.st == ST_DONE |-> $stable(s_r.sval))
    else $error("captured sync value changed");
  a_run_tick: assert property (
    s_r.st == ST_RUN && !tick_sy && !brk_hit && !s_r.rst_busy |=> s_r.sval == $past(s_r.sval))
    else $error("sync timer moved without its enable");
  a_off_frozen: assert property (
    !s_r.en && !s_r.rst_busy |=> $stable(s_r.st) && !brk_hit)
    else $error("sync logic active while disabled");
  a_rst_hold: assert property ($rose(s_r.rst_busy) |-> s_r.rst_busy[*8])
    else $error("sync reset released too early");
  a_rst_done: assert property (
    $fell(s_r.rst_busy) |-> s_r.f_rdone && s_r.cmp == CMP_RST
      && s_r.setup == SETUP_RST && $past(s_r.rst_cnt) == SELF_CLR_LAST)
    else $error("sync reset did not restore defaults");
  a_stop_irq: assert property (
    stop_hit && s_r.stop_ie |=> lin_irq && s_r.st == ST_DONE)
    else $error("stop edge did not raise interrupt");

  c_break_seen: cover property (brk_hit);
  c_stop_seen: cover property (stop_hit);
  c_overflow: cover property (ovf);
  c_reset_done: cover property ($fell(s_r.rst_busy));
endmodule

// [tb/lsu_lin_master.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// lin master: drives the single-wire bus, and drives it high itself when released
// ---------------------------------------------------------------------------
module lsu_lin_master (
  input  wire logic clock,
  output logic      lin_rx
);
  initial begin
    lin_rx = 1'b1;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  // dominant pulse of n clocks, then released to recessive
  task automatic drive_low(input int n);
    @(posedge clock);
    lin_rx <= 1'b0;
    repeat (n) @(posedge clock);
    lin_rx <= 1'b1;
  endtask

  // start bit, eight data bits lsb first, stop bit; bc clocks per bit
  task automatic send_byte(input logic [7:0] b, input int bc);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      lin_rx <= fr[i];
      repeat (bc) @(posedge clock);
    end
  endtask
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top
  import lsu_pkg::*;
;
  logic        clock;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        lin_rx;
  logic        lin_irq;
  logic [31:0] q;
  logic [31:0] v1;
  logic        e;
  int          num_errors;
  int          n_compared;
  localparam int BRK = LP_DIV;

  lsu_lin_sync i_dut (
    .clock   (clock),
    .rst_b   (rst_b),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .lin_rx  (lin_rx),
    .lin_irq (lin_irq)
  );

  lsu_lin_master i_master (
    .clock  (clock),
    .lin_rx (lin_rx)
  );

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic final_report();
    $display("compared %0d, mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      final_report();
    end else begin
      rq = prdata;
      re = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] dq;
    logic        de;
    apb(1'b1, a, d, dq, de);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] rq);
    logic de;
    apb(1'b0, a, 32'h00000000, rq, de);
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_defaults();
    rd(ADDR_EDGE_SETUP, q);
    chk(q, 32'h00000032);
    rd(ADDR_SYNC_VALUE, q);
    chk(q, 32'h00000000);
    rd(ADDR_BREAK_TIMER, q);
    chk(q, 32'h00000000);
    rd(ADDR_SYNC_CONTROL, q);
    chk(q & 32'h00000004, 32'h00000000);
    wr(ADDR_EDGE_SETUP, 32'h00000062);
    rd(ADDR_EDGE_SETUP, q);
    chk(q, 32'h00000062);
    wr(ADDR_BREAK_TIMER, 32'h00000ABC);
    rd(ADDR_BREAK_TIMER, q);
    chk(q, 32'h00000000);
    apb(1'b0, 32'hFFFF07A0, 32'h00000000, q, e);
    chk({31'h0, e}, 32'h00000001);
    $display("test defaults done");
  endtask

  task automatic t_no_break();
    wr(ADDR_BREAK_TIMER, 32'h00000004);
    wr(ADDR_SYNC_CONTROL, 32'h00000000);
    i_master.drive_low(6 * BRK + BRK / 2);
    i_master.idle(20);
    rd(ADDR_SYNC_STATUS, q);
    chk(q & 32'h00000011, 32'h00000000);
    wr(ADDR_SYNC_CONTROL, 32'h00000004);
    i_master.drive_low(2 * BRK);
    i_master.send_byte(8'h55, 100);
    i_master.idle(20);
    rd(ADDR_SYNC_STATUS, q);
    chk(q & 32'h00000013, 32'h00000000);
    rd(ADDR_SYNC_VALUE, q);
    chk(q, 32'h00000000);
    $display("test no_break done");
  endtask

  task automatic t_header();
    wr(ADDR_EDGE_SETUP, 32'h00000062);
    wr(ADDR_SYNC_CONTROL, 32'h00000014);
    wr(ADDR_BREAK_TIMER, 32'h00000004);
    rd(ADDR_SYNC_STATUS, q);
    i_master.send_byte(8'h00, 100);
    i_master.drive_low(6 * BRK + BRK / 2);
    i_master.idle(20);
    #1;
    chk({31'h0, lin_irq}, 32'h00000001);
    rd(ADDR_SYNC_STATUS, q);
    chk(q & 32'h00000011, 32'h00000001);
    rd(ADDR_BREAK_TIMER, q);
    chk_rng(q, 32'h00000006, 32'h00000007);
    rd(ADDR_BREAK_TIMER, q);
    chk(q, 32'h00000000);
    i_master.send_byte(8'h55, 100);
    i_master.idle(20);
    #1;
    chk({31'h0, lin_irq}, 32'h00000001);
    rd(ADDR_SYNC_VALUE, v1);
    chk_rng(v1, 32'h0000001F, 32'h00000021);
    rd(ADDR_SYNC_STATUS, q);
    chk(q & 32'h00000013, 32'h00000002);
    #1;
    chk({31'h0, lin_irq}, 32'h00000000);
    i_master.send_byte(8'h55, 100);
    rd(ADDR_SYNC_VALUE, q);
    chk(q, v1);
    $display("test header done");
  endtask

  task automatic t_sync_reset();
    time t0;
    int  n;
    wr(ADDR_EDGE_SETUP, 32'h00000062);
    wr(ADDR_SYNC_CONTROL, 32'h00000001);
    t0 = $time;
    rd(ADDR_SYNC_CONTROL, q);
    chk(q & 32'h00000001, 32'h00000001);
    rd(ADDR_SYNC_STATUS, v1);
    chk(v1 & 32'h00000020, 32'h00000000);
    n = 0;
    while (q[0] !== 1'b0 && n < 1500) begin
      rd(ADDR_SYNC_CONTROL, q);
      n++;
    end
    if (q[0] !== 1'b0) begin
      num_errors++;
      final_report();
    end
    chk_rng(32'(($time - t0) / 8), 32'h00000744, 32'h00000762);
    rd(ADDR_EDGE_SETUP, q);
    chk(q, 32'h00000032);
    rd(ADDR_SYNC_STATUS, q);
    chk(q & 32'h00000020, 32'h00000020);
    $display("test sync_reset done");
  endtask

  // stop on the sixth rising edge, start interrupt enabled too
  task automatic t_rise_stop();
    wr(ADDR_EDGE_SETUP, 32'h00000062);
    wr(ADDR_BREAK_TIMER, 32'h00000004);
    wr(ADDR_SYNC_CONTROL, 32'h0000009C);
    rd(ADDR_SYNC_STATUS, q);
    i_master.drive_low(6 * BRK + BRK / 2);
    i_master.idle(20);
    rd(ADDR_SYNC_STATUS, q);
    chk(q & 32'h00000017, 32'h00000001);
    i_master.send_byte(8'h55, 100);
    i_master.idle(20);
    #1;
    chk({31'h0, lin_irq}, 32'h00000001);
    rd(ADDR_SYNC_STATUS, q);
    chk(q & 32'h00000017, 32'h00000006);
    rd(ADDR_SYNC_VALUE, q);
    chk_rng(q, 32'h00000023, 32'h00000025);
    $display("test rise_stop done");
  endtask

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial begin
    num_errors = 0;
    n_compared = 0;
    rst_b   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 32'h00000000;
    pwdata  = 32'h00000000;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    t_defaults();
    t_no_break();
    t_header();
    t_sync_reset();
    t_rise_stop();
    final_report();
  end
endmodule
